/* File: verilog/stx_exec.sv */
// execution unit for subtract, fault sync, system control, test and dma update
// assumes one instruction issued at a time; memory reads answer via mem_rvalid
//
// How it works
// [RULE1] carry subtract gives src2 minus src1 minus not carry
// [RULE2] carry bit is carry out of src2 plus not src1 plus carry
// [RULE3] carry subtract sets overflow bit on signed overflow for any type
// [RULE4] signed and unsigned subtract both store src2 minus src1
// [RULE5] signed overflow faults, or sets sticky flag when masked
// [RULE6] non-supervisor special register operand raises type-mismatch fault
// [RULE7] fault sync stalls until no imprecise faults, unless disabled
// [RULE8] system control runs the command in src1 message field
// [RULE9] unused operand fields and reserved bits are ignored
// [RULE10] posted interrupt takes vector from type field, updates pending priority
// [RULE11] lowered priority compares against stored pending priority
// [RULE12] cache mode field selects enable, disable, full lock, half lock
// [RULE13] full lock fills 1 Kbyte, half lock fills 512 bytes
// [RULE14] software gives lock load address ending in binary 10
// [RULE15] reinitialize loads control block at src3, resumes at src2
// [RULE16] load control group reads four words into registers 0 to 3
// [RULE17] unknown message code raises invalid-operand fault
// [RULE18] test writes 01h when mask and condition nonzero, else 00h
// [RULE19] test-not-ordered is true only for condition 000
// [RULE20] test opcodes 20h-27h hold mask in bits 0 to 2
// [RULE21] dma update copies status of channels 0 to 3 into dma ram
// [RULE22] tests leave condition code untouched, write destination only
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module stx_exec (
  input wire logic clk_sys,
  input wire logic rst,
  // instruction issue
  input wire logic issue_valid,
  input wire logic [11:0] issue_opcode,
  input wire logic [31:0] src1,
  input wire logic [31:0] src2,
  input wire logic [31:0] src3,
  input wire logic [2:0] condition_code_field,
  input wire logic overflow_mask_bit,
  input wire logic no_imprecise_faults_bit,
  input wire logic supervisor,
  input wire logic sfr_operand,
  input wire logic imprecise_pending,
  input wire logic [4:0] prio_new,
  input wire logic prio_lower,
  input wire logic [127:0] dma_status,
  // memory read port for control block and control table
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  output logic mem_req,
  output logic [31:0] mem_addr,
  // results
  output logic done,
  output logic [31:0] dst_data,
  output logic dst_we,
  output logic [2:0] cc_out,
  output logic cc_we,
  output logic sticky_overflow_flag,
  output logic fault_overflow,
  output logic fault_type,
  output logic fault_invalid,
  output logic irq_post,
  output logic [7:0] irq_vector,
  output logic irq_take,
  output logic cache_invalidate,
  output logic [1:0] cache_state,
  output logic cache_fill,
  output logic [31:0] cache_fill_addr,
  output logic [10:0] cache_fill_bytes,
  output logic soft_reset,
  output logic [31:0] resume_ip,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ********************************
  // state
  // ********************************
  typedef enum {ST_IDLE, ST_SYNC, ST_CBLK, ST_CREG} stx_phase_t;
  typedef struct packed {
    stx_phase_t phase;
    logic [2:0] ctrl;
    logic [31:0] ctbl;
    logic [4:0] pend_prio;
    logic [3:0] widx;
    logic [31:0] ip_hold;
    logic [127:0] creg;
    logic [127:0] cblk;
    logic [127:0] dma_ram;
    logic mem_req;
    logic [31:0] mem_addr;
    logic done;
    logic [31:0] dst_data;
    logic dst_we;
    logic [2:0] cc_out;
    logic cc_we;
    logic sof;
    logic f_ovf;
    logic f_type;
    logic f_inv;
    logic irq_post;
    logic [7:0] irq_vector;
    logic irq_take;
    logic cinv;
    logic [1:0] cstate;
    logic cfill;
    logic [31:0] cfill_addr;
    logic [10:0] cfill_bytes;
    logic soft_reset;
    logic [31:0] resume_ip;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } stx_state_t;
  stx_state_t s_r;
  stx_state_t s_nxt;

  // 33-bit add used by both subtract flavours
  function automatic logic [32:0] add33(input logic [31:0] a, input logic [31:0] b,
                                        input logic cin);
    add33 = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
  endfunction

  // signed overflow of a - b given the difference
  function automatic logic sub_ovf(input logic [31:0] a, input logic [31:0] b,
                                   input logic [31:0] d);
    sub_ovf = (a[31] != b[31]) && (d[31] != a[31]);
  endfunction

  logic [32:0] sum;
  logic ovf;
  logic apb_go;
  logic [7:0] msg;
  logic [7:0] ftype;
  assign apb_go = psel && penable && !s_r.pready;
  // src1 layout: message in bits 15:8, type in bits 7:0, rest reserved
  assign msg = src1[15:8];
  assign ftype = src1[7:0];

  // ********************************
  // next state
  // ********************************
  always_comb begin
    s_nxt = s_r;
    sum = 33'h0_0000_0000;
    ovf = 1'b0;
    // single-cycle strobes fall back every cycle
    s_nxt.done = 1'b0;
    s_nxt.dst_we = 1'b0;
    s_nxt.cc_we = 1'b0;
    s_nxt.f_ovf = 1'b0;
    s_nxt.f_type = 1'b0;
    s_nxt.f_inv = 1'b0;
    s_nxt.irq_post = 1'b0;
    s_nxt.irq_take = 1'b0;
    s_nxt.cinv = 1'b0;
    s_nxt.cfill = 1'b0;
    s_nxt.soft_reset = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    // [RULE11] priority drop checks stored pending priority
    if (prio_lower && (s_r.pend_prio > prio_new)) begin
      s_nxt.irq_take = 1'b1;
    end
    case (s_r.phase)
      ST_IDLE: begin
        if (issue_valid) begin
          // [RULE6] sfr access check
          if (sfr_operand && !supervisor) begin
            s_nxt.f_type = 1'b1;
            s_nxt.done = 1'b1;
          end else if (issue_opcode == stx_pkg::OP_SUB_CARRY) begin
            // [RULE1] subtract with carry
            sum = add33(src2, ~src1, condition_code_field[1]);
            s_nxt.dst_data = sum[31:0];
            s_nxt.dst_we = 1'b1;
            // [RULE2] [RULE3] carry and overflow bits
            s_nxt.cc_out = {1'b0, sum[32], sub_ovf(src2, src1, sum[31:0])};
            s_nxt.cc_we = 1'b1;
            s_nxt.done = 1'b1;
          end else if (issue_opcode == stx_pkg::OP_SUB_INT ||
                       issue_opcode == stx_pkg::OP_SUB_ORD) begin
            // [RULE4] same binary result for both
            sum = add33(src2, ~src1, 1'b1);
            s_nxt.dst_data = sum[31:0];
            s_nxt.dst_we = 1'b1;
            s_nxt.done = 1'b1;
            ovf = (issue_opcode == stx_pkg::OP_SUB_INT) && sub_ovf(src2, src1, sum[31:0]);
            // [RULE5] overflow fault or sticky flag
            if (ovf) begin
              if (overflow_mask_bit) begin
                s_nxt.sof = 1'b1;
              end else begin
                s_nxt.f_ovf = 1'b1;
              end
            end
          end else if (issue_opcode == stx_pkg::OP_FAULT_SYNC) begin
            // [RULE7] wait for imprecise faults to drain
            if (!no_imprecise_faults_bit && imprecise_pending) begin
              s_nxt.phase = ST_SYNC;
            end else begin
              s_nxt.done = 1'b1;
            end
          end else if (issue_opcode >= stx_pkg::OP_TEST_LO &&
                       issue_opcode <= stx_pkg::OP_TEST_HI) begin
            // [RULE20] [RULE18] [RULE19] [RULE22] test into dst only
            if (issue_opcode[2:0] == 3'h0) begin
              s_nxt.dst_data = {24'h00_0000, (condition_code_field == 3'h0) ?
                                stx_pkg::TRUE_VAL : stx_pkg::FALSE_VAL};
            end else begin
              s_nxt.dst_data = {24'h00_0000,
                                ((issue_opcode[2:0] & condition_code_field) != 3'h0) ?
                                stx_pkg::TRUE_VAL : stx_pkg::FALSE_VAL};
            end
            s_nxt.dst_we = 1'b1;
            s_nxt.done = 1'b1;
          end else if (issue_opcode == stx_pkg::OP_DMA_UPDATE) begin
            // [RULE21] snapshot all four channels
            s_nxt.dma_ram = dma_status;
            s_nxt.done = 1'b1;
          end else if (issue_opcode == stx_pkg::OP_SYS_CTRL) begin
            // [RULE8] [RULE9] dispatch on message, unused fields ignored
            case (msg)
              stx_pkg::MSG_REQ_IRQ: begin
                // [RULE10] post and track highest pending priority
                s_nxt.irq_post = 1'b1;
                s_nxt.irq_vector = ftype;
                if (ftype[7:3] > s_r.pend_prio) begin
                  s_nxt.pend_prio = ftype[7:3];
                end
                s_nxt.done = 1'b1;
              end
              stx_pkg::MSG_INV_CACHE: begin
                s_nxt.cinv = 1'b1;
                s_nxt.done = 1'b1;
              end
              stx_pkg::MSG_CFG_CACHE: begin
                // [RULE12] [RULE13] cache mode select and fill size
                // src2 low bits must be 10 for locking, as software provides
                s_nxt.done = 1'b1;
                if (ftype[0]) begin
                  s_nxt.cstate = stx_pkg::CST_DISABLED;
                end else if (ftype[2:0] == stx_pkg::CMODE_NORMAL) begin
                  s_nxt.cstate = stx_pkg::CST_ENABLED;
                end else if (ftype[2:0] == stx_pkg::CMODE_LOCK_FULL) begin
                  s_nxt.cstate = stx_pkg::CST_LOCK_FULL;
                  s_nxt.cfill = 1'b1;
                  s_nxt.cfill_addr = src2;
                  s_nxt.cfill_bytes = stx_pkg::LOCK_FULL_BYTES;
                end else if (ftype[2:0] == stx_pkg::CMODE_LOCK_HALF) begin
                  s_nxt.cstate = stx_pkg::CST_LOCK_HALF;
                  s_nxt.cfill = 1'b1;
                  s_nxt.cfill_addr = src2;
                  s_nxt.cfill_bytes = stx_pkg::LOCK_HALF_BYTES;
                end
              end
              stx_pkg::MSG_REINIT: begin
                // [RULE15] fetch control block, then resume
                s_nxt.phase = ST_CBLK;
                s_nxt.ip_hold = src2;
                s_nxt.widx = 4'h0;
                s_nxt.mem_req = 1'b1;
                s_nxt.mem_addr = src3;
              end
              stx_pkg::MSG_LOAD_CREG: begin
                // [RULE16] four words from table base plus group offset
                s_nxt.phase = ST_CREG;
                s_nxt.widx = 4'h0;
                s_nxt.mem_req = 1'b1;
                s_nxt.mem_addr = s_r.ctbl + {20'h0_0000, ftype, 4'h0};
              end
              default: begin
                // [RULE17] unknown command
                s_nxt.f_inv = 1'b1;
                s_nxt.done = 1'b1;
              end
            endcase
          end else begin
            s_nxt.f_inv = 1'b1;
            s_nxt.done = 1'b1;
          end
        end
      end
      ST_SYNC: begin
        // [RULE7] release once drained
        if (!imprecise_pending) begin
          s_nxt.phase = ST_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      ST_CBLK, ST_CREG: begin
        if (mem_rvalid) begin
          // [RULE16] words land in index order
          if (s_r.phase == ST_CREG) begin
            s_nxt.creg[s_r.widx[1:0]*32 +: 32] = mem_rdata;
          end else begin
            s_nxt.cblk[s_r.widx[1:0]*32 +: 32] = mem_rdata;
          end
          s_nxt.widx = s_r.widx + 4'h1;
          s_nxt.mem_addr = s_r.mem_addr + 32'h0000_0004;
          if (s_r.widx == stx_pkg::CREG_WORDS - 4'h1) begin
            s_nxt.mem_req = 1'b0;
            s_nxt.phase = ST_IDLE;
            s_nxt.done = 1'b1;
            if (s_r.phase == ST_CBLK) begin
              // [RULE15] software reset then resume at src2
              s_nxt.soft_reset = 1'b1;
              s_nxt.resume_ip = s_r.ip_hold;
              s_nxt.pend_prio = 5'h00;
            end
          end
        end
      end
      default: s_nxt.phase = ST_IDLE;
    endcase
    // apb slave, one wait state; sticky flag set wins over clear
    if (apb_go) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      if (pwrite) begin
        case (paddr)
          stx_pkg::REG_CTRL: begin
            s_nxt.ctrl = pwdata[2:0];
            if (pwdata[0] && !(ovf && overflow_mask_bit)) begin
              s_nxt.sof = 1'b0;
            end
          end
          stx_pkg::REG_CTBL_BASE: s_nxt.ctbl = pwdata;
          default: s_nxt.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          stx_pkg::REG_CTRL: s_nxt.prdata = {29'h0000_0000, s_r.ctrl};
          stx_pkg::REG_STATUS: s_nxt.prdata = {27'h000_0000, s_r.cstate,
                                              s_r.phase != ST_IDLE, s_r.sof, 1'b0};
          stx_pkg::REG_PEND_PRIO: s_nxt.prdata = {27'h000_0000, s_r.pend_prio};
          stx_pkg::REG_CTBL_BASE: s_nxt.prdata = s_r.ctbl;
          default: begin
            if (paddr[7:4] == stx_pkg::REG_CREG_BASE[7:4] && paddr[1:0] == 2'h0) begin
              s_nxt.prdata = s_r.creg[paddr[3:2]*32 +: 32];
            end else if (paddr[7:4] == stx_pkg::REG_DMA_BASE[7:4] && paddr[1:0] == 2'h0) begin
              s_nxt.prdata = s_r.dma_ram[paddr[3:2]*32 +: 32];
            end else begin
              s_nxt.pslverr = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.phase <= ST_IDLE;
      s_r.ctbl <= stx_pkg::CTBL_RESET;
      s_r.ctrl <= stx_pkg::CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state flops
  assign mem_req = s_r.mem_req;
  assign mem_addr = s_r.mem_addr;
  assign done = s_r.done;
  assign dst_data = s_r.dst_data;
  assign dst_we = s_r.dst_we;
  assign cc_out = s_r.cc_out;
  assign cc_we = s_r.cc_we;
  assign sticky_overflow_flag = s_r.sof;
  assign fault_overflow = s_r.f_ovf;
  assign fault_type = s_r.f_type;
  assign fault_invalid = s_r.f_inv;
  assign irq_post = s_r.irq_post;
  assign irq_vector = s_r.irq_vector;
  assign irq_take = s_r.irq_take;
  assign cache_invalidate = s_r.cinv;
  assign cache_state = s_r.cstate;
  assign cache_fill = s_r.cfill;
  assign cache_fill_addr = s_r.cfill_addr;
  assign cache_fill_bytes = s_r.cfill_bytes;
  assign soft_reset = s_r.soft_reset;
  assign resume_ip = s_r.resume_ip;
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;

  // ********************************
  // checks
  // ********************************
  a_subc_result: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
    (issue_valid && s_r.phase == ST_IDLE && issue_opcode == stx_pkg::OP_SUB_CARRY &&
     !(sfr_operand && !supervisor)) |=> dst_we &&
     dst_data == $past(src2) - $past(src1) - {31'h0, !$past(condition_code_field[1])})
    else $error("carry subtract result wrong");
  a_sub_same: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
    (issue_valid && s_r.phase == ST_IDLE && issue_opcode == stx_pkg::OP_SUB_ORD &&
     !(sfr_operand && !supervisor)) |=> dst_data == $past(src2) - $past(src1))
    else $error("subtract result wrong");
  a_ovf_masked: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
    fault_overflow |-> !$past(overflow_mask_bit))
    else $error("masked overflow still faulted");
  a_type_fault: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
    (issue_valid && s_r.phase == ST_IDLE && sfr_operand && !supervisor)
    |=> fault_type && !dst_we)
    else $error("sfr fault missing");
  a_sync_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
    (s_r.phase == ST_SYNC && imprecise_pending) |=> !done)
    else $error("sync released early");
  a_test_cc: assert property (@(posedge clk_sys) disable iff (rst) // [RULE22]
    (issue_valid && s_r.phase == ST_IDLE && issue_opcode[11:3] == 9'h004 &&
     !(sfr_operand && !supervisor)) |=> !cc_we && dst_data[31:1] == 31'h0)
    else $error("test wrote condition code");
  a_bad_msg: assert property (@(posedge clk_sys) disable iff (rst) // [RULE17]
    (issue_valid && s_r.phase == ST_IDLE && issue_opcode == stx_pkg::OP_SYS_CTRL &&
     !(sfr_operand && !supervisor) && msg > stx_pkg::MSG_LOAD_CREG)
    |=> fault_invalid && !irq_post && !soft_reset)
    else $error("bad message not refused");
  a_creg_four: assert property (@(posedge clk_sys) disable iff (rst) // [RULE16]
    (s_r.phase == ST_CREG && mem_rvalid && s_r.widx == 4'h3) |=> done && !mem_req)
    else $error("control group load not four words");
endmodule

/* File: verilog/stx_pkg.sv */
// constants shared by the subtract/test/system-control execution block
// assumes a single 100 MHz core clock and an APB register port
package stx_pkg;
  // ********************************
  // opcodes
  // ********************************
  localparam logic [11:0] OP_SUB_CARRY = 12'h5b2;
  localparam logic [11:0] OP_SUB_INT = 12'h593;
  localparam logic [11:0] OP_SUB_ORD = 12'h592;
  localparam logic [11:0] OP_FAULT_SYNC = 12'h66f;
  localparam logic [11:0] OP_SYS_CTRL = 12'h659;
  localparam logic [11:0] OP_DMA_UPDATE = 12'h631;
  localparam logic [11:0] OP_TEST_LO = 12'h020;
  localparam logic [11:0] OP_TEST_HI = 12'h027;
  // ********************************
  // system-control message codes
  // ********************************
  localparam logic [7:0] MSG_REQ_IRQ = 8'h00;
  localparam logic [7:0] MSG_INV_CACHE = 8'h01;
  localparam logic [7:0] MSG_CFG_CACHE = 8'h02;
  localparam logic [7:0] MSG_REINIT = 8'h03;
  localparam logic [7:0] MSG_LOAD_CREG = 8'h04;
  // cache mode patterns
  localparam logic [2:0] CMODE_NORMAL = 3'h0;
  localparam logic [2:0] CMODE_LOCK_FULL = 3'h4;
  localparam logic [2:0] CMODE_LOCK_HALF = 3'h6;
  localparam logic [10:0] LOCK_FULL_BYTES = 11'h400;
  localparam logic [10:0] LOCK_HALF_BYTES = 11'h200;
  // cache state encoding
  localparam logic [1:0] CST_ENABLED = 2'h0;
  localparam logic [1:0] CST_DISABLED = 2'h1;
  localparam logic [1:0] CST_LOCK_FULL = 2'h2;
  localparam logic [1:0] CST_LOCK_HALF = 2'h3;
  localparam logic [7:0] TRUE_VAL = 8'h01;
  localparam logic [7:0] FALSE_VAL = 8'h00;
  localparam logic [3:0] CREG_WORDS = 4'h4;
  localparam logic [4:0] CBLK_WORDS = 5'h4;
  // ********************************
  // apb register map (byte offsets)
  // ********************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PEND_PRIO = 8'h08;
  localparam logic [7:0] REG_CREG_BASE = 8'h10;
  localparam logic [7:0] REG_DMA_BASE = 8'h20;
  localparam logic [7:0] REG_CTBL_BASE = 8'h30;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [31:0] CTBL_RESET = 32'h0000_0000;
endpackage

/* File: testbench/tb.sv */
// self-checking bench for the subtract, test and system-control execution unit
// assumes stx_exec raises done or pready for each request, however many cycles later; the bench drives every port itself
`timescale 1ns/1ns
module tb;
  // ********************************
  // signals and design instance
  // ********************************
  logic clk_sys = 0, rst = 1, issue_valid = 0, overflow_mask_bit = 0;
  logic no_imprecise_faults_bit = 0, supervisor = 1, sfr_operand = 0, imprecise_pending = 0;
  logic prio_lower = 0, mem_rvalid = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [11:0] issue_opcode = 0;
  logic [31:0] src1 = 0, src2 = 0, src3 = 0, mem_rdata = 0, pwdata = 0, rd, first_addr = 0;
  logic [2:0] condition_code_field = 0;
  logic [4:0] prio_new = 0;
  logic [7:0] paddr = 0, irq_vector;
  logic [127:0] dma_status = 0;
  logic mem_req, done, dst_we, cc_we, sticky_overflow_flag, fault_overflow, fault_type;
  logic fault_invalid, irq_post, irq_take, cache_invalidate, cache_fill, soft_reset;
  logic pready, pslverr;
  logic [31:0] mem_addr, dst_data, cache_fill_addr, resume_ip, prdata;
  logic [2:0] cc_out;
  logic [1:0] cache_state;
  logic [10:0] cache_fill_bytes;
  int err_total = 0, comparisons = 0, lat, words = 0;
  stx_exec dut_u (
    .clk_sys, .rst, .issue_valid, .issue_opcode, .src1, .src2, .src3, .condition_code_field,
    .overflow_mask_bit, .no_imprecise_faults_bit, .supervisor, .sfr_operand,
    .imprecise_pending, .prio_new, .prio_lower, .dma_status, .mem_rvalid, .mem_rdata,
    .mem_req, .mem_addr, .done, .dst_data, .dst_we, .cc_out, .cc_we, .sticky_overflow_flag,
    .fault_overflow, .fault_type, .fault_invalid, .irq_post, .irq_vector, .irq_take,
    .cache_invalidate, .cache_state, .cache_fill, .cache_fill_addr, .cache_fill_bytes,
    .soft_reset, .resume_ip, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  always #5 clk_sys = ~clk_sys;
  // memory answers every other cycle, so the loader must cope with gaps; four words at most
  always @(posedge clk_sys) begin
    mem_rvalid <= mem_req && !mem_rvalid && words < 4;
    mem_rdata <= mem_addr + 32'h0000_0100;
    words <= mem_req ? words + int'(mem_rvalid) : 0;
    if (mem_rvalid && words == 0) first_addr <= mem_addr;
  end
  // ********************************
  // shared tasks
  // ********************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // apb master: request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // pready is sampled at the rising edge itself; the watchdog ends a hang
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // issue one instruction; returns in the cycle that shows done, lat counts the wait
  task automatic run(input logic [11:0] o, input logic [31:0] a, b, c);
    @(posedge clk_sys);
    issue_valid <= 1;
    issue_opcode <= o;
    src1 <= a;
    src2 <= b;
    src3 <= c;
    @(posedge clk_sys);
    issue_valid <= 0;
    #1;
    // no cycle limit here: the watchdog ends a hang
    for (lat = 0; done !== 1'b1; lat++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic sub_carry(input logic [31:0] a, b, input logic cin);
    logic [32:0] sum;
    logic v;
    sum = {1'b0, b} + {1'b0, ~a} + 33'(cin);
    v = (a[31] != b[31]) && (sum[31] != b[31]);
    condition_code_field <= {1'b0, cin, 1'b0};
    run(stx_pkg::OP_SUB_CARRY, a, b, 32'h0);
    chk(dst_data, sum[31:0], "carry subtract result");
    chk({28'h0, cc_we, cc_out}, {29'h1, 1'b0, sum[32], v}, "carry flags");
  endtask
  // one priority lowering; exp says whether a pending interrupt must be taken
  task automatic lower(input logic [4:0] p, input logic exp);
    logic seen;
    seen = 0;
    @(posedge clk_sys);
    prio_new <= p;
    prio_lower <= 1;
    @(posedge clk_sys);
    prio_lower <= 0;
    repeat (3) begin
      #1;
      seen = seen | irq_take;
      @(posedge clk_sys);
    end
    chk({31'h0, seen}, {31'h0, exp}, "priority take");
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_sub();
    sub_carry(32'h5, 32'h3, 1'b1);
    sub_carry(32'h1, 32'h8000_0000, 1'b0);
    sub_carry(32'hffff_ffff, 32'h7fff_ffff, 1'b1);
    run(stx_pkg::OP_SUB_INT, 32'h1, 32'h8000_0000, 32'h0);
    chk({fault_overflow, dst_data[30:0]}, 32'hffff_ffff, "signed overflow faults");
    overflow_mask_bit <= 1;
    run(stx_pkg::OP_SUB_INT, 32'h1, 32'h8000_0000, 32'h0);
    chk({fault_overflow, sticky_overflow_flag}, 32'h1, "masked overflow");
    run(stx_pkg::OP_SUB_ORD, 32'h1, 32'h8000_0000, 32'h0);
    chk({fault_overflow, dst_data[30:0]}, 32'h7fff_ffff, "unsigned same bits");
    apb(1'b1, stx_pkg::REG_CTRL, 32'h1);
    chk({31'h0, sticky_overflow_flag}, 32'h0, "sticky cleared");
    overflow_mask_bit <= 0;
    supervisor <= 0;
    sfr_operand <= 1;
    run(stx_pkg::OP_SUB_ORD, 32'h1, 32'h2, 32'h0);
    chk({31'h0, fault_type}, 32'h1, "user special register");
    supervisor <= 1;
    sfr_operand <= 0;
    $display("test subtract finished");
  endtask
  task automatic t_test();
    logic [7:0] e;
    for (int m = 0; m < 8; m++) begin
      for (int c = 0; c < 8; c++) begin
        condition_code_field <= 3'(c);
        e = (m == 0) ? 8'(c == 0) : 8'((m & c) != 0);
        run(stx_pkg::OP_TEST_LO + 12'(m), 32'h0, 32'h0, 32'h0);
        chk(dst_data, {24'h0, e}, "test value");
        chk({30'h0, cc_we, dst_we}, 32'h1, "test writes only dst");
      end
    end
    $display("test condition finished");
  endtask
  task automatic t_sync();
    imprecise_pending <= 1;
    fork
      run(stx_pkg::OP_FAULT_SYNC, 32'h0, 32'h0, 32'h0);
      begin
        repeat (12) @(posedge clk_sys);
        imprecise_pending <= 0;
      end
    join
    chk({31'h0, lat > 8}, 32'h1, "sync stalls");
    no_imprecise_faults_bit <= 1;
    imprecise_pending <= 1;
    run(stx_pkg::OP_FAULT_SYNC, 32'h0, 32'h0, 32'h0);
    chk({31'h0, lat < 2}, 32'h1, "sync skipped");
    no_imprecise_faults_bit <= 0;
    imprecise_pending <= 0;
    $display("test sync finished");
  endtask
  task automatic t_sysctl();
    run(stx_pkg::OP_SYS_CTRL, {16'hffff, stx_pkg::MSG_REQ_IRQ, 8'h48}, 32'hdead_beef, 32'h0);
    chk({23'h0, irq_post, irq_vector}, 32'h148, "interrupt posted");
    apb(1'b0, stx_pkg::REG_PEND_PRIO, 32'h0);
    chk(rd, 32'h9, "stored priority");
    lower(5'h4, 1'b1);
    lower(5'h1f, 1'b0);
    run(stx_pkg::OP_SYS_CTRL, {16'h0, stx_pkg::MSG_INV_CACHE, 8'h0}, 32'h0, 32'h0);
    chk({31'h0, cache_invalidate}, 32'h1, "invalidate");
    run(stx_pkg::OP_SYS_CTRL, {16'h0, 8'h09, 8'h0}, 32'h0, 32'h0);
    chk({fault_invalid, cache_invalidate, irq_post, soft_reset}, 32'h8, "bad code");
    run(stx_pkg::OP_SYS_CTRL, {16'h0, stx_pkg::MSG_REINIT, 8'h0}, 32'h4000, 32'h8000);
    chk({soft_reset, resume_ip[30:0]}, 32'h8000_4000, "reinit resume");
    chk(first_addr, 32'h8000, "control block address");
    apb(1'b1, stx_pkg::REG_CTBL_BASE, 32'h1000);
    run(stx_pkg::OP_SYS_CTRL, {16'h0, stx_pkg::MSG_LOAD_CREG, 8'h02}, 32'h0, 32'h0);
    chk(first_addr, 32'h1020, "group table address");
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, stx_pkg::REG_CREG_BASE + 8'(4 * i), 32'h0);
      chk(rd, 32'h1120 + 32'(4 * i), "control register word");
    end
    $display("test system control finished");
  endtask
  task automatic t_cache();
    logic [2:0] md [5] = '{3'h0, 3'h7, 3'h4, 3'h2, 3'h6};
    logic [1:0] st [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
    logic [11:0] fl [5] = '{12'h0, 12'h0, 12'hc00, 12'h400, 12'ha00};
    for (int i = 0; i < 5; i++) begin
      run(stx_pkg::OP_SYS_CTRL, {16'h0, stx_pkg::MSG_CFG_CACHE, 5'h0, md[i]}, 32'h2002, 32'h0);
      chk({20'h0, cache_fill, cache_fill_bytes}, {20'h0, fl[i]}, "fill size");
      if (fl[i][11]) chk(cache_fill_addr, 32'h2002, "fill address");
      @(posedge clk_sys);
      #1;
      chk({30'h0, cache_state}, {30'h0, st[i]}, "cache mode");
    end
    $display("test cache finished");
  endtask
  task automatic t_dma();
    dma_status <= {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
    run(stx_pkg::OP_DMA_UPDATE, 32'h0, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, stx_pkg::REG_DMA_BASE + 8'(4 * i), 32'h0);
      chk(rd, 32'h1111_1111 * 32'(i + 1), "dma ram word");
    end
    apb(1'b0, 8'hfc, 32'h0);
    chk({31'h0, perr}, 32'h1, "unmapped refused");
    $display("test dma finished");
  endtask
  // ********************************
  // sequence and verdict
  // ********************************
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 0;
    apb(1'b0, stx_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0, "status after reset");
    t_sub();
    t_test();
    t_sync();
    t_sysctl();
    t_cache();
    t_dma();
    give_verdict();
  end
  // watchdog: the whole run needs a few hundred cycles, so 50k cycles means a hang
  initial begin
    #500000;
    err_total++;
    give_verdict();
  end
endmodule
